/* File: hw/drm_defs.vh */
`ifndef DRM_DEFS_VH
`define DRM_DEFS_VH
// register byte offsets
`define DRM_A_CTRL      8'h00
`define DRM_A_MIN_IN    8'h04
`define DRM_A_MAX_IN    8'h08
`define DRM_A_FILT      8'h0C
`define DRM_A_LOW_FREQ  8'h10
`define DRM_A_HIGH_FREQ 8'h14
`define DRM_A_FUNC_A    8'h18
`define DRM_A_FUNC_B    8'h1C
`define DRM_A_JOG_FREQ  8'h20
`define DRM_A_PRIMARY   8'h24
`define DRM_A_PRESET0   8'h40
`define DRM_A_PRESET14  8'h78
`define DRM_A_STATUS    8'h80
`define DRM_A_FREQ      8'h84
`define DRM_A_FILT_OUT  8'h88
// control fields
`define DRM_CTRL_CUR    0
`define DRM_CTRL_LODIR  1
`define DRM_CTRL_HIDIR  2
// reset values
`define DRM_RST_MIN     8'h00
`define DRM_RST_MAX     8'h64
`define DRM_RST_FILT    4'h1
`define DRM_RST_LOW     17'h00000
`define DRM_RST_HIGH    17'h01388
`define DRM_RST_FUNC_A  32'h09120706
`define DRM_RST_FUNC_B  32'h00000000
`define DRM_RST_JOG     17'h001F4
`define DRM_RST_PRIM    17'h01388
// limits and scaling
`define DRM_FREQ_MAX    17'h1868C
`define DRM_FILT_MAX    4'hA
`define DRM_MV_STEP     7'h64
`define DRM_CUR_FLOOR   14'h03E8
// timing
`define DRM_CLK_MHZ     25
`define DRM_TICK_US     1000
// one tick is DRM_TICK_US at DRM_CLK_MHZ, held at the counter's width
`define DRM_TICK_CYC    15'h61A8
`endif

/* File: hw/drm_io_mapper.v */
// How it works
// - Filtered reference below the minimum input is invalid; no frequency comes from it.
// - Reference above the maximum input is clamped to the maximum.
// - Reference passes a low-pass filter, 0 to 1.0 s; longer is slower.
// - Min and max bound the range; current mode uses 4 mA=1 V, 20 mA=5 V.
// - Minimum input gives low-point frequency, 0 to 999.8 Hz in 0.01 Hz.
// - Maximum input gives high-point frequency, default 50 Hz, same range.
// - Low-point direction bit: 0 forward, 1 reverse, default forward.
// - High-point direction bit: 0 forward, 1 reverse, default forward.
// - Low-point frequency may exceed high-point, giving a falling curve.
// - Current mode: input below 4 mA is an invalid reference.
// - Each terminal has a function code; defaults 6, 7, 18, 9, rest 0.
// - Codes: 0 none, 1 jog, 2 jog forward, 3 jog reverse, 5 run.
// - Code 4 selects reverse while active, forward while inactive.
// - Forward plus direction select: on/off forward, on/on reverse, off/off stop.
// - Codes 6, 7, 8 command forward, reverse and stop.
// - Jog uses a jog frequency, normally 5 Hz.
// - Codes 9 to 12 are preset-speed bits selecting one of 15 presets.
// - No bit: primary source; singles 1-4, pairs 5-10, triples 11-14, all 15.
// - Codes 13 to 26 and 32 decode to their functions; others reserved.
// - Two ramp bits pick one of four ramp pairs; both off picks first.
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`include "drm_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module drm_io_mapper #(
  parameter [14:0] TICK_CYCLES = `DRM_TICK_CYC
) (
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  input  wire [13:0] analog_ref_input_in,
  input  wire [7:0]  terminals_in,
  output reg  [16:0] freq_out,
  output reg         reverse_out,
  output reg         run_out,
  output reg         inching_run_out,
  output reg         ref_valid_out,
  output reg  [3:0]  preset_index_out,
  output reg  [1:0]  ramp_select_out,
  output reg         freq_up_out,
  output reg         freq_down_out,
  output reg         emergency_halt_out,
  output reg         fault_reset_out,
  output reg         regulator_enable_out,
  output reg         sequencer_enable_out,
  output reg         timer_one_start_out,
  output reg         timer_two_start_out,
  output reg         counter_pulse_out,
  output reg         counter_reset_out,
  output reg         pause_out,
  output reg         channel_switch_out,
  output reg         thermistor_out
);
  localparam [0:0] ST_IDLE = 1'b0;
  localparam [0:0] ST_DIV  = 1'b1;

  reg  [2:0]  ctrl_q;
  reg  [7:0]  min_q;
  reg  [7:0]  max_q;
  reg  [3:0]  filt_q;
  reg  [16:0] low_q;
  reg  [16:0] high_q;
  reg  [31:0] func_a_q;
  reg  [31:0] func_b_q;
  reg  [16:0] jog_q;
  reg  [16:0] prim_q;
  reg  [16:0] preset_q [0:14];
  reg         aw_have_q;
  reg         w_have_q;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg  [14:0] tick_cnt_q;
  reg         tick_q;
  reg  [23:0] filt_acc_q;
  reg  [0:0]  state_q;
  reg  [5:0]  bit_cnt_q;
  reg  [31:0] num_q;
  reg  [15:0] rem_q;
  reg  [15:0] den_q;
  reg         neg_q;
  reg  [19:0] base_q;
  reg         span_zero_q;
  reg  [16:0] ana_mag_q;
  reg         ana_neg_q;
  reg  [31:0] rd_d;
  reg         rd_ok_d;
  reg  [31:0] wr_word;
  reg  [16:0] wr_freq;
  reg  [4:0]  shift_d;
  reg  [15:0] rem_d;
  reg  [3:0]  pidx_d;
  reg  [16:0] mag_d;
  integer     i;
  integer     j;

  wire [32:0] func_vec [0:7];
  wire [32:0] act;
  wire [13:0] filt_mv;
  wire [14:0] min_mv;
  wire [14:0] max_mv;
  wire [14:0] x_clamp;
  wire        ref_ok;
  wire [19:0] lo_s;
  wire [19:0] hi_s;
  wire [19:0] diff_s;
  wire [19:0] diff_mag;
  wire [31:0] product;
  wire [20:0] ana_s;
  wire        wr_go;
  wire [7:0]  rd_addr;
  wire [3:0]  pre_off;
  wire [3:0]  pidx_sel;
  wire        jog_any;
  wire        halt_any;
  wire        fwd_cmd;
  wire        rev_cmd;

  // terminal decode: each of 0..7 by its own function code, 0 forward and 1 reverse by default
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_term
      drm_term_dec u_dec (
        .code_in   ((g < 4) ? func_a_q[8*(g%4) +: 6] : func_b_q[8*(g%4) +: 6]),
        .active_in (terminals_in[g]),
        .func_out  (func_vec[g])
      );
    end
  endgenerate
  assign act = func_vec[0] | func_vec[1] | func_vec[2] | func_vec[3]
             | func_vec[4] | func_vec[5] | func_vec[6] | func_vec[7];

  // bus write path: address and data may arrive in either order
  assign wr_go   = aw_have_q && w_have_q && !s_axi_bvalid_out;
  assign pre_off = awaddr_q[5:2];
  always @* begin
    wr_word = rd_d;
    for (i = 0; i < 4; i = i + 1) begin
      if (wstrb_q[i]) begin
        wr_word[8*i +: 8] = wdata_q[8*i +: 8];
      end
    end
    // out-of-range values in bits 16:0 saturate rather than wrap; bits 31:17 are dropped first
    wr_freq = (wr_word[16:0] > `DRM_FREQ_MAX) ? `DRM_FREQ_MAX : wr_word[16:0];
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= 2'b00;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      ctrl_q    <= 3'h0;
      min_q     <= `DRM_RST_MIN;
      max_q     <= `DRM_RST_MAX;
      filt_q    <= `DRM_RST_FILT;
      low_q     <= `DRM_RST_LOW;
      high_q    <= `DRM_RST_HIGH;
      func_a_q  <= `DRM_RST_FUNC_A;
      func_b_q  <= `DRM_RST_FUNC_B;
      jog_q     <= `DRM_RST_JOG;
      prim_q    <= `DRM_RST_PRIM;
      for (j = 0; j < 15; j = j + 1) begin
        preset_q[j] <= 17'h00000;
      end
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        awaddr_q          <= s_axi_awaddr_in;
        aw_have_q         <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        wdata_q          <= s_axi_wdata_in;
        wstrb_q          <= s_axi_wstrb_in;
        w_have_q         <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
      if (wr_go) begin
        aw_have_q        <= 1'b0;
        w_have_q         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= 2'b00;
        case (awaddr_q)
          `DRM_A_CTRL:      ctrl_q   <= wr_word[2:0];
          `DRM_A_MIN_IN:    min_q    <= wr_word[7:0];
          `DRM_A_MAX_IN:    max_q    <= wr_word[7:0];
          `DRM_A_FILT:      filt_q   <= (wr_word[3:0] > `DRM_FILT_MAX) ? `DRM_FILT_MAX
                                        : wr_word[3:0];
          `DRM_A_LOW_FREQ:  low_q    <= wr_freq;
          `DRM_A_HIGH_FREQ: high_q   <= wr_freq;
          `DRM_A_FUNC_A:    func_a_q <= wr_word & 32'h3F3F3F3F;
          `DRM_A_FUNC_B:    func_b_q <= wr_word & 32'h3F3F3F3F;
          `DRM_A_JOG_FREQ:  jog_q    <= wr_freq;
          `DRM_A_PRIMARY:   prim_q   <= wr_freq;
          default: begin
            if (awaddr_q >= `DRM_A_PRESET0 && awaddr_q <= `DRM_A_PRESET14 && awaddr_q[1:0] == 2'b00) begin
              preset_q[pre_off] <= wr_freq;
            end else if (awaddr_q != `DRM_A_STATUS && awaddr_q != `DRM_A_FREQ
                         && awaddr_q != `DRM_A_FILT_OUT) begin
              s_axi_bresp_out <= 2'b10;
            end
          end
        endcase
      end
    end
  end

  // read mux; the write path reuses it on the latched write address
  assign rd_addr = wr_go ? awaddr_q
                 : (s_axi_arvalid_in && s_axi_arready_out ? s_axi_araddr_in : awaddr_q);
  always @* begin
    rd_d    = 32'h00000000;
    rd_ok_d = 1'b1;
    case (rd_addr)
      `DRM_A_CTRL:      rd_d = {29'h0, ctrl_q};
      `DRM_A_MIN_IN:    rd_d = {24'h0, min_q};
      `DRM_A_MAX_IN:    rd_d = {24'h0, max_q};
      `DRM_A_FILT:      rd_d = {28'h0, filt_q};
      `DRM_A_LOW_FREQ:  rd_d = {15'h0, low_q};
      `DRM_A_HIGH_FREQ: rd_d = {15'h0, high_q};
      `DRM_A_FUNC_A:    rd_d = func_a_q;
      `DRM_A_FUNC_B:    rd_d = func_b_q;
      `DRM_A_JOG_FREQ:  rd_d = {15'h0, jog_q};
      `DRM_A_PRIMARY:   rd_d = {15'h0, prim_q};
      `DRM_A_STATUS:    rd_d = {20'h0, ramp_select_out, preset_index_out, ana_neg_q,
                                ref_valid_out, inching_run_out, reverse_out, run_out,
                                emergency_halt_out};
      `DRM_A_FREQ:      rd_d = {15'h0, freq_out};
      `DRM_A_FILT_OUT:  rd_d = {18'h0, filt_mv};
      default: begin
        if (rd_addr >= `DRM_A_PRESET0 && rd_addr <= `DRM_A_PRESET14 && rd_addr[1:0] == 2'b00) begin
          rd_d = {15'h0, preset_q[rd_addr[5:2]]};
        end else begin
          rd_ok_d = 1'b0;
        end
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= 2'b00;
    end else if (s_axi_rvalid_out) begin
      if (s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end else if (s_axi_arvalid_in && s_axi_arready_out && !wr_go) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_d;
      s_axi_rresp_out   <= rd_ok_d ? 2'b00 : 2'b10;
    end
  end

  // filter tick and first-order low-pass on the reference
  always @* begin
    case (filt_q)
      4'h0: shift_d = 5'd0;
      4'h1: shift_d = 5'd7;
      4'h2: shift_d = 5'd8;
      4'h3: shift_d = 5'd8;
      4'h4: shift_d = 5'd9;
      4'h5: shift_d = 5'd9;
      default: shift_d = 5'd10;
    endcase
  end
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      tick_cnt_q <= 15'h0000;
      tick_q     <= 1'b0;
      filt_acc_q <= 24'h000000;
    end else begin
      tick_q <= (tick_cnt_q == TICK_CYCLES - 15'h0001);
      tick_cnt_q <= (tick_cnt_q == TICK_CYCLES - 15'h0001) ? 15'h0000 : tick_cnt_q + 15'h0001;
      if (tick_q) begin
        // shift approximates a time constant of filt_q tenths of a second in 1 ms steps
        if (shift_d == 5'd0) begin
          filt_acc_q <= {analog_ref_input_in, 10'h000};
        end else begin
          filt_acc_q <= filt_acc_q + (({analog_ref_input_in, 10'h000} >> shift_d)
                        - (filt_acc_q >> shift_d));
        end
      end
    end
  end
  assign filt_mv = filt_acc_q[23:10];

  // scaling: all points in millivolts on the internal scale
  assign min_mv  = min_q * `DRM_MV_STEP;
  assign max_mv  = max_q * `DRM_MV_STEP;
  assign ref_ok  = ({1'b0, filt_mv} >= min_mv)
                 && !(ctrl_q[`DRM_CTRL_CUR] && filt_mv < `DRM_CUR_FLOOR);
  assign x_clamp = ({1'b0, filt_mv} > max_mv) ? max_mv : {1'b0, filt_mv};
  assign lo_s    = ctrl_q[`DRM_CTRL_LODIR] ? -{3'b000, low_q} : {3'b000, low_q};
  assign hi_s    = ctrl_q[`DRM_CTRL_HIDIR] ? -{3'b000, high_q} : {3'b000, high_q};
  assign diff_s  = hi_s - lo_s;
  assign diff_mag = diff_s[19] ? -diff_s : diff_s;
  assign product = diff_mag * {17'h00000, x_clamp - min_mv};

  // sequential divide gives |hi-lo|*(x-min)/(max-min), 32 steps per tick
  always @* begin
    rem_d = {rem_q[14:0], num_q[31]};
  end
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 6'h00;
      num_q       <= 32'h00000000;
      rem_q       <= 16'h0000;
      den_q       <= 16'h0000;
      neg_q       <= 1'b0;
      base_q      <= 20'h00000;
      span_zero_q <= 1'b0;
      ana_mag_q   <= 17'h00000;
      ana_neg_q   <= 1'b0;
      ref_valid_out <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (tick_q) begin
            num_q       <= product;
            rem_q       <= 16'h0000;
            den_q       <= {1'b0, max_mv - min_mv};
            span_zero_q <= (max_mv <= min_mv);
            neg_q       <= diff_s[19];
            base_q      <= lo_s;
            bit_cnt_q   <= 6'h00;
            ref_valid_out <= ref_ok;
            state_q     <= ST_DIV;
          end
        end
        ST_DIV: begin
          if (rem_d >= den_q) begin
            rem_q <= rem_d - den_q;
            num_q <= {num_q[30:0], 1'b1};
          end else begin
            rem_q <= rem_d;
            num_q <= {num_q[30:0], 1'b0};
          end
          bit_cnt_q <= bit_cnt_q + 6'h01;
          if (bit_cnt_q == 6'h1F) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (state_q == ST_DIV && bit_cnt_q == 6'h20 - 6'h01) begin
        // a degenerate span falls back to the high point
        ana_mag_q <= span_zero_q ? (hi_s[19] ? -hi_s[16:0] : hi_s[16:0])
                   : (ana_s[20] ? -ana_s[16:0] : ana_s[16:0]);
        ana_neg_q <= span_zero_q ? hi_s[19] : ana_s[20];
      end
    end
  end
  assign ana_s = {base_q[19], base_q}
               + (neg_q ? -{1'b0, num_q[18:0], (rem_d >= den_q)}
                        : {1'b0, num_q[18:0], (rem_d >= den_q)});

  // command decode from the terminal functions
  assign jog_any  = act[1] | act[2] | act[3];
  assign halt_any = act[8] | act[17];
  assign fwd_cmd  = act[6] | act[5] | jog_any;
  assign rev_cmd  = act[7];
  assign pidx_sel = {act[12], act[11], act[10], act[9]};
  always @* begin
    case (pidx_sel)
      4'h0: pidx_d = 4'h0;
      4'h1: pidx_d = 4'h1;
      4'h2: pidx_d = 4'h2;
      4'h4: pidx_d = 4'h3;
      4'h8: pidx_d = 4'h4;
      4'h3: pidx_d = 4'h5;
      4'h5: pidx_d = 4'h6;
      4'h9: pidx_d = 4'h7;
      4'h6: pidx_d = 4'h8;
      4'hA: pidx_d = 4'h9;
      4'hC: pidx_d = 4'hA;
      4'h7: pidx_d = 4'hB;
      4'hB: pidx_d = 4'hC;
      4'hD: pidx_d = 4'hD;
      4'hE: pidx_d = 4'hE;
      default: pidx_d = 4'hF;
    endcase
    if (jog_any) begin
      mag_d = jog_q;
    end else if (pidx_d != 4'h0) begin
      mag_d = preset_q[pidx_d - 4'h1];
    end else if (ref_valid_out) begin
      mag_d = ana_mag_q;
    end else begin
      mag_d = prim_q;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      freq_out             <= 17'h00000;
      reverse_out          <= 1'b0;
      run_out              <= 1'b0;
      inching_run_out      <= 1'b0;
      preset_index_out     <= 4'h0;
      ramp_select_out      <= 2'h0;
      freq_up_out          <= 1'b0;
      freq_down_out        <= 1'b0;
      emergency_halt_out   <= 1'b0;
      fault_reset_out      <= 1'b0;
      regulator_enable_out <= 1'b0;
      sequencer_enable_out <= 1'b0;
      timer_one_start_out  <= 1'b0;
      timer_two_start_out  <= 1'b0;
      counter_pulse_out    <= 1'b0;
      counter_reset_out    <= 1'b0;
      pause_out            <= 1'b0;
      channel_switch_out   <= 1'b0;
      thermistor_out       <= 1'b0;
    end else begin
      freq_out         <= mag_d;
      // direction select alone still runs, in reverse
      run_out          <= !halt_any && (fwd_cmd | rev_cmd | act[4]);
      reverse_out      <= jog_any ? (act[3] & ~act[2])
                        : ((rev_cmd & ~act[6]) | act[4])
                          ^ (pidx_d == 4'h0 && ref_valid_out && ana_neg_q);
      inching_run_out  <= jog_any && !halt_any;
      preset_index_out <= pidx_d;
      ramp_select_out  <= {act[14], act[13]};
      freq_up_out          <= act[15];
      freq_down_out        <= act[16];
      emergency_halt_out   <= act[17];
      fault_reset_out      <= act[18];
      regulator_enable_out <= act[19];
      sequencer_enable_out <= act[20];
      timer_one_start_out  <= act[21];
      timer_two_start_out  <= act[22];
      counter_pulse_out    <= act[23];
      counter_reset_out    <= act[24];
      pause_out            <= act[25];
      channel_switch_out   <= act[26];
      thermistor_out       <= act[32];
    end
  end
endmodule // drm_io_mapper
`default_nettype wire

/* File: hw/drm_term_dec.v */
`timescale 1ns/10ps
`default_nettype none
// one-hot decode of a terminal's function code, gated by the terminal level
module drm_term_dec (
  input  wire [5:0]  code_in,
  input  wire        active_in,
  output wire [32:0] func_out
);
  // reserved codes 27..31 and anything above 32 decode to nothing
  wire usable;
  assign usable   = active_in && (code_in <= 6'h1A || code_in == 6'h20);
  assign func_out = usable ? (33'h000000001 << code_in) : 33'h000000000;
endmodule // drm_term_dec
`default_nettype wire

/* File: verif/drm_far_end.sv */
`timescale 1ns/10ps
`default_nettype none
module drm_far_end (
  input  wire logic        clk_in,
  input  wire logic        cur_mode_in,
  input  wire logic [15:0] level_in,
  input  wire logic [7:0]  term_req_in,
  output var  logic [13:0] ref_mv_out = 14'h0000,
  output var  logic [7:0]  term_out = 8'h00
);
  logic [15:0] mv;
  // current loop front end: 4 mA..20 mA (in uA) lands on 1000..5000 mV
  assign mv = cur_mode_in ? (level_in >> 2) : level_in;
  always @(posedge clk_in) begin
    ref_mv_out <= (mv > 16'h3FFF) ? 14'h3FFF : mv[13:0];
    term_out   <= term_req_in;
  end
endmodule // drm_far_end
`default_nettype wire

/* File: verif/drm_io_mapper_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module drm_io_mapper_assertions (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic [16:0] freq_out,
  input wire logic        run_out,
  input wire logic        emergency_halt_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  a_ready_return: assert property (s_axi_bvalid_out && s_axi_bready_in
    |=> !s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out) else $error("no reopen");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_awready_out
    && s_axi_wready_out && !s_axi_awvalid_in && !s_axi_wvalid_in
    |=> s_axi_rvalid_out && !s_axi_arready_out) else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  a_refuse_zero: assert property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2
    |-> s_axi_rdata_out == 32'h0) else $error("refused read carries data");
  a_freq_ceiling:
    assert property (freq_out <= 17'h1868C) else $error("frequency above ceiling");
  a_halt_stops:
    assert property (emergency_halt_out |-> !run_out) else $error("run during halt");
endmodule // drm_io_mapper_assertions
bind drm_io_mapper drm_io_mapper_assertions chk_u (.clk_in, .rst_b_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in,
  .s_axi_rdata_out, .s_axi_rresp_out, .freq_out, .run_out, .emergency_halt_out);
`default_nettype wire

/* File: verif/drm_io_mapper_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "drm_defs.vh"
module drm_io_mapper_tb;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, treq = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, cur = 0;
  logic [15:0] lvl = 16'h0000;
  logic [1:0]  rs;
  wire  [1:0]  bresp, rresp, ramp;
  wire  [31:0] rdata;
  wire  [16:0] freq;
  wire  [13:0] mv;
  wire  [7:0]  terms;
  wire  [3:0]  pidx;
  wire  [12:0] misc;
  wire         awready, wready, bvalid, arready, rvalid, reverse_cmd_terminal, run, inching_run, refv;
  int          bad_count = 0, samples_checked = 0;
  localparam logic [7:0]  ADR [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
    8'h20, 8'h24};
  localparam logic [31:0] RST [10] = '{32'h0, 32'h0, 32'h64, 32'h1, 32'h0, 32'h1388,
    32'h09120706, 32'h0, 32'h1F4, 32'h1388};
  localparam int PIX [16] = '{0, 1, 2, 5, 3, 6, 8, 11, 4, 7, 9, 12, 10, 13, 14, 15};
  always #20 clk_in = ~clk_in;
  drm_far_end far_u (.clk_in(clk_in), .cur_mode_in(cur), .level_in(lvl), .term_req_in(treq),
    .ref_mv_out(mv), .term_out(terms));
  drm_io_mapper #(.TICK_CYCLES(15'h0032)) dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .analog_ref_input_in(mv),
    .terminals_in(terms), .freq_out(freq), .reverse_out(reverse_cmd_terminal), .run_out(run),
    .inching_run_out(inching_run), .ref_valid_out(refv), .preset_index_out(pidx),
    .ramp_select_out(ramp), .freq_up_out(misc[0]), .freq_down_out(misc[1]),
    .emergency_halt_out(misc[2]), .fault_reset_out(misc[3]), .regulator_enable_out(misc[4]),
    .sequencer_enable_out(misc[5]), .timer_one_start_out(misc[6]),
    .timer_two_start_out(misc[7]), .counter_pulse_out(misc[8]), .counter_reset_out(misc[9]),
    .pause_out(misc[10]), .channel_switch_out(misc[11]), .thermistor_out(misc[12]));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // up to two ticks (filter, then divide) plus the 32-step divide fit inside 150 cycles
  task apply(input logic [7:0] t, input logic [15:0] lv);
    @(posedge clk_in);
    treq <= t;
    lvl <= lv;
    repeat (150) @(posedge clk_in);
  endtask
  task results;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_in);
    bad_count++;
    results;
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rdr(ADR[i]);
      chk(rd, RST[i]);
    end
    rdr(8'hFC);
    chk(rs, 2'h2);
    chk(rd, 32'h0);
    wr(8'hFC, 32'h1);
    chk(rs, 2'h2);
    wr(`DRM_A_FREQ, 32'h123);
    chk(rs, 2'h0);
    wr(`DRM_A_FILT, 32'hF);
    rdr(`DRM_A_FILT);
    chk(rd, 32'hA);
    wr(`DRM_A_FILT, 32'h0);
    apply(8'h00, 16'h1388);
    chk({refv, freq}, {1'b1, 17'h9C4});
    apply(8'h00, 16'h2EE0);
    chk(freq, 17'h1388);
    wr(`DRM_A_CTRL, 32'h2);
    wr(`DRM_A_MIN_IN, 32'h14);
    wr(`DRM_A_LOW_FREQ, 32'h1388);
    apply(8'h00, 16'h07D0);
    chk({reverse_cmd_terminal, freq}, {1'b1, 17'h1388});
    apply(8'h00, 16'h0FA0);
    chk({reverse_cmd_terminal, freq}, {1'b1, 17'h9C4});
    apply(8'h00, 16'h1770);
    chk(freq, 17'h0);
    apply(8'h00, 16'h2710);
    chk({reverse_cmd_terminal, freq}, {1'b0, 17'h1388});
    apply(8'h00, 16'h03E8);
    chk({refv, freq}, {1'b0, 17'h1388});
    wr(`DRM_A_CTRL, 32'h6);
    apply(8'h00, 16'h2710);
    chk({reverse_cmd_terminal, freq}, {1'b1, 17'h1388});
    wr(`DRM_A_CTRL, 32'h1);
    wr(`DRM_A_MIN_IN, 32'hA);
    wr(`DRM_A_MAX_IN, 32'h32);
    wr(`DRM_A_LOW_FREQ, 32'h2710);
    wr(`DRM_A_HIGH_FREQ, 32'h0);
    cur <= 1'b1;
    apply(8'h00, 16'h2EE0);
    chk(freq, 17'h1388);
    wr(`DRM_A_MIN_IN, 32'h5);
    apply(8'h00, 16'h0ED8);
    chk(refv, 1'b0);
    cur <= 1'b0;
    wr(`DRM_A_CTRL, 32'h0);
    wr(`DRM_A_MIN_IN, 32'h0);
    wr(`DRM_A_MAX_IN, 32'h64);
    wr(`DRM_A_FILT, 32'hA);
    apply(8'h00, 16'h2710);
    rdr(`DRM_A_FILT_OUT);
    chk(rd < 32'h1388, 1'b1);
    wr(`DRM_A_FILT, 32'h0);
    apply(8'h01, 16'h2710);
    rdr(`DRM_A_FILT_OUT);
    chk(rd, 32'h2710);
    chk({run, reverse_cmd_terminal}, 2'h2);
    apply(8'h02, 16'h2710);
    chk({run, reverse_cmd_terminal}, 2'h3);
    apply(8'h04, 16'h2710);
    chk(misc[3], 1'b1);
    wr(`DRM_A_FUNC_A, 32'h09120406);
    apply(8'h01, 16'h2710);
    chk({run, reverse_cmd_terminal}, 2'h2);
    apply(8'h03, 16'h2710);
    chk({run, reverse_cmd_terminal}, 2'h3);
    apply(8'h00, 16'h2710);
    chk(run, 1'b0);
    wr(`DRM_A_FUNC_B, 32'h8);
    apply(8'h11, 16'h2710);
    chk(run, 1'b0);
    for (int i = 0; i < 16; i++) begin
      wr(`DRM_A_FUNC_B, (i < 14) ? 13 + i : ((i == 14) ? 32 : 27));
      apply(8'h10, 16'h2710);
      chk({misc, ramp}, (i < 15) ? (1 << i) : 0);
    end
    wr(`DRM_A_FUNC_B, 32'h1);
    apply(8'h10, 16'h2710);
    chk({inching_run, freq}, {1'b1, 17'h1F4});
    wr(`DRM_A_FUNC_B, 32'h3);
    apply(8'h10, 16'h2710);
    chk({inching_run, reverse_cmd_terminal}, 2'h3);
    rdr(`DRM_A_STATUS);
    chk(rd, 32'h1E);
    wr(`DRM_A_FUNC_B, 32'h2);
    apply(8'h10, 16'h2710);
    chk({inching_run, reverse_cmd_terminal}, 2'h2);
    wr(`DRM_A_FUNC_B, 32'h5);
    apply(8'h10, 16'h2710);
    chk(run, 1'b1);
    wr(`DRM_A_FUNC_B, 32'h0C0B0A09);
    for (int k = 1; k < 16; k++)
      wr(`DRM_A_PRESET0 + 4 * (k - 1), 100 * k);
    for (int m = 0; m < 16; m++) begin
      apply({m[3:0], 4'h0}, 16'h2710);
      chk({pidx, freq}, {PIX[m][3:0], 17'(100 * PIX[m])});
    end
    results;
  end
endmodule // drm_io_mapper_tb
`default_nettype wire
